//--- logic/cpr0_pkg.sv
// Purpose: Constants for the card port zero pin routing block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Pin index order follows the general-purpose pin numbering
`default_nettype none
package cpr0_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int unsigned CPR0_AW = 4;
   localparam logic [3:0] CPR0_BUS_SELECT_OFS = 4'h0;
   localparam logic [3:0] CPR0_PD_INHIBIT_OFS = 4'h4;
   localparam logic [3:0] CPR0_CPU_STATUS_OFS = 4'h8;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int unsigned CPR0_PIN_N     = 6;
   localparam int unsigned CPR0_ROUTE_LSB = 0;
   localparam int unsigned CPR0_ROUTE_W   = 2;
   localparam int unsigned CPR0_FLAG_BIT  = 13;
   localparam int unsigned CPR0_FLAG_LANE = 1;
   localparam int unsigned CPR0_ROUTE_LANE = 0;
   localparam int unsigned CPR0_PD_LANE    = 0;
   localparam logic [1:0] CPR0_ROUTE_CARD  = 2'h0;
   localparam logic [1:0] CPR0_ROUTE_AUDIO = 2'h1;
   localparam logic [1:0] CPR0_ROUTE_GPIO  = 2'h2;
   localparam logic [1:0] CPR0_ROUTE_RST   = 2'h2;
   localparam logic [5:0] CPR0_PD_RST      = 6'h00;
   localparam logic       CPR0_FLAG_RST    = 1'h0;

   // Pins that may carry the audio port
   localparam logic [5:0] CPR0_AUDIO_MASK = 6'h0F;

   // ----------------------------------------
   // Pin positions
   // ----------------------------------------
   localparam int unsigned CPR0_PIN_CLK = 0;
   localparam int unsigned CPR0_PIN_CMD = 1;
   localparam int unsigned CPR0_PIN_D0  = 2;
   localparam int unsigned CPR0_PIN_D1  = 3;
   localparam int unsigned CPR0_PIN_D3  = 5;

   // ----------------------------------------
   // Bus responses
   // ----------------------------------------
   localparam logic [1:0] CPR0_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CPR0_RESP_SLVERR = 2'h2;
endpackage : cpr0_pkg
`default_nettype wire

//--- logic/cpr0_pin_route.sv
// Purpose: Pin routing for card port zero and the external flag pin
// Assumes: All inputs synchronous to mclk_in; pads resolve enables
// Notes:   Routed pad signals are registered, one cycle of latency
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - The clock pin carries card clock, audio bit clock or gpio pin 0 per the route field.
// - The command pin carries card command, audio frame sync or gpio pin 1 per the route field.
// - The upper two data pins carry card data or gpio pins 5 and 4, never the audio port.
// - The lower two data pins carry card data, audio receive/transmit or gpio pins 3 and 2.
// - In card mode the four data pins form one 4-bit bus steered by the card controller.
// - One route field in the bus select register picks the function of all six pins.
// - Each pin's pulldown is enabled or inhibited by its own bit, whatever the function.
// - The bit set instruction aimed at the flag drives the flag pin high.
// - The bit clear instruction, or a write of status bit 13, drives the flag accordingly.
// - The flag pin is always driven, and floats only during boundary scan.
// - The flag pin is output only, usable as fast output or processor signal.
module cpr0_pin_route
   import cpr0_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                mclk_in,
   input  wire logic                resetn_in,
   input  wire logic                ce_in,
   // AXI4-Lite write
   input  wire logic [CPR0_AW-1:0]  s_awaddr_in,
   input  wire logic                s_awvalid_in,
   output logic                     s_awready_out,
   input  wire logic [31:0]         s_wdata_in,
   input  wire logic [3:0]          s_wstrb_in,
   input  wire logic                s_wvalid_in,
   output logic                     s_wready_out,
   output logic [1:0]               s_bresp_out,
   output logic                     s_bvalid_out,
   input  wire logic                s_bready_in,
   // AXI4-Lite read
   input  wire logic [CPR0_AW-1:0]  s_araddr_in,
   input  wire logic                s_arvalid_in,
   output logic                     s_arready_out,
   output logic [31:0]              s_rdata_out,
   output logic [1:0]               s_rresp_out,
   output logic                     s_rvalid_out,
   input  wire logic                s_rready_in,
   // Card controller
   input  wire logic                card_clk_in,
   input  wire logic                card_cmd_in,
   input  wire logic                card_cmd_oe_in,
   output logic                     card_cmd_out,
   input  wire logic [3:0]          card_dat_in,
   input  wire logic [3:0]          card_dat_oe_in,
   output logic [3:0]               card_dat_out,
   // Audio port
   input  wire logic                aud_clk_in,
   input  wire logic                aud_clk_oe_in,
   output logic                     aud_clk_out,
   input  wire logic                aud_fs_in,
   input  wire logic                aud_fs_oe_in,
   output logic                     aud_fs_out,
   input  wire logic                aud_dx_in,
   output logic                     aud_rx_out,
   // GPIO block
   input  wire logic [5:0]          gpio_val_in,
   input  wire logic [5:0]          gpio_oe_in,
   output logic [5:0]               gpio_pad_out,
   // Card port pads
   input  wire logic [5:0]          pad_in,
   output logic [5:0]               pad_out,
   output logic [5:0]               pad_oe_out,
   output logic [5:0]               pd_inhibit_out,
   // CPU flag control and scan
   input  wire logic                flag_set_in,
   input  wire logic                flag_clr_in,
   input  wire logic                scan_in,
   output logic                     flag_out,
   output logic                     flag_oe_out
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [1:0]          route_ff;
   logic [5:0]          pdi_ff;
   logic                flag_ff;
   logic                flag_oe_ff;
   logic                aw_hold_ff;
   logic                w_hold_ff;
   logic [CPR0_AW-1:0]  awaddr_ff;
   logic [31:0]         wdata_ff;
   logic [3:0]          wstrb_ff;
   logic                bvalid_ff;
   logic [1:0]          bresp_ff;
   logic                rvalid_ff;
   logic [31:0]         rdata_ff;
   logic [1:0]          rresp_ff;
   logic                wr_fire;
   logic                wr_route;
   logic                wr_pd;
   logic                wr_flag;
   logic                wr_hit;
   logic [31:0]         nxt_rdata;
   logic                rd_hit;

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   // Ready only when frozen state can move; one write in flight
   assign s_awready_out = ce_in & ~aw_hold_ff & ~bvalid_ff;
   assign s_wready_out  = ce_in & ~w_hold_ff & ~bvalid_ff;
   assign s_arready_out = ce_in & ~rvalid_ff;
   assign s_bvalid_out  = bvalid_ff;
   assign s_bresp_out   = bresp_ff;
   assign s_rvalid_out  = rvalid_ff;
   assign s_rdata_out   = rdata_ff;
   assign s_rresp_out   = rresp_ff;

   // Commit once both address and data are held
   assign wr_fire  = ce_in & aw_hold_ff & w_hold_ff;
   assign wr_route = wr_fire & (awaddr_ff == CPR0_BUS_SELECT_OFS)
                     & wstrb_ff[CPR0_ROUTE_LANE];
   assign wr_pd    = wr_fire & (awaddr_ff == CPR0_PD_INHIBIT_OFS)
                     & wstrb_ff[CPR0_PD_LANE];
   assign wr_flag  = wr_fire & (awaddr_ff == CPR0_CPU_STATUS_OFS)
                     & wstrb_ff[CPR0_FLAG_LANE];
   assign wr_hit   = (awaddr_ff == CPR0_BUS_SELECT_OFS)
                     | (awaddr_ff == CPR0_PD_INHIBIT_OFS)
                     | (awaddr_ff == CPR0_CPU_STATUS_OFS);

   // Address and data captured independently, either order
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
      end else if (ce_in) begin
         if (s_awvalid_in && s_awready_out) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff  <= s_awaddr_in;
         end else if (wr_fire) begin
            aw_hold_ff <= 1'b0;
         end
         if (s_wvalid_in && s_wready_out) begin
            w_hold_ff <= 1'b1;
            wdata_ff  <= s_wdata_in;
            wstrb_ff  <= s_wstrb_in;
         end else if (wr_fire) begin
            w_hold_ff <= 1'b0;
         end
      end
   end

   // Write response, error for unmapped addresses
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= CPR0_RESP_OKAY;
      end else if (ce_in) begin
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? CPR0_RESP_OKAY : CPR0_RESP_SLVERR;
         end else if (s_bready_in) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Read mux, reserved bits read zero
   always_comb begin
      nxt_rdata = '0;
      rd_hit    = 1'b1;
      case (s_araddr_in)
         CPR0_BUS_SELECT_OFS: begin
            nxt_rdata[CPR0_ROUTE_LSB +: CPR0_ROUTE_W] = route_ff;
         end
         CPR0_PD_INHIBIT_OFS: begin
            nxt_rdata[CPR0_PIN_N-1:0] = pdi_ff;
         end
         CPR0_CPU_STATUS_OFS: begin
            nxt_rdata[CPR0_FLAG_BIT] = flag_ff;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read data valid one cycle after address accepted
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= CPR0_RESP_OKAY;
      end else if (ce_in) begin
         if (s_arvalid_in && s_arready_out) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= rd_hit ? CPR0_RESP_OKAY : CPR0_RESP_SLVERR;
         end else if (s_rready_in) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Single field steers all six pins
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         route_ff <= CPR0_ROUTE_RST;
      end else if (wr_route) begin
         route_ff <= wdata_ff[CPR0_ROUTE_LSB +: CPR0_ROUTE_W];
      end
   end

   // Pulldown inhibit, untouched by routing changes
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pdi_ff <= CPR0_PD_RST;
      end else if (wr_pd) begin
         pdi_ff <= wdata_ff[CPR0_PIN_N-1:0];
      end
   end
   assign pd_inhibit_out = pdi_ff;

   // Flag: instructions outrank a status write in the same cycle
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flag_ff <= CPR0_FLAG_RST;
      end else if (ce_in) begin
         if (flag_set_in) begin
            flag_ff <= 1'b1;
         end else if (flag_clr_in) begin
            flag_ff <= 1'b0;
         end else if (wr_flag) begin
            flag_ff <= wdata_ff[CPR0_FLAG_BIT];
         end
      end
   end

   // Flag never has an input path; floats only in scan
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flag_oe_ff <= 1'b1;
      end else if (ce_in) begin
         flag_oe_ff <= ~scan_in;
      end
   end
   assign flag_out    = flag_ff;
   assign flag_oe_out = flag_oe_ff;

   // ----------------------------------------
   // Per-pin routing
   // ----------------------------------------
   logic [5:0] card_o;
   logic [5:0] card_e;
   logic [5:0] aud_o;
   logic [5:0] aud_e;
   logic [5:0] pad_o_ff;
   logic [5:0] pad_e_ff;
   logic [5:0] card_i_ff;
   logic [5:0] aud_i_ff;
   logic [5:0] gpio_i_ff;

   // Card clock is always driven; data bus is one nibble
   assign card_o = {card_dat_in, card_cmd_in, card_clk_in};
   assign card_e = {card_dat_oe_in, card_cmd_oe_in, 1'b1};
   // Receive pin is input only, transmit pin always driven
   assign aud_o  = {2'b00, 1'b0, aud_dx_in, aud_fs_in, aud_clk_in};
   assign aud_e  = {2'b00, 1'b0, 1'b1, aud_fs_oe_in, aud_clk_oe_in};

   for (genvar i = 0; i < CPR0_PIN_N; i++) begin : g_pin
      logic sel_card;
      logic sel_aud;
      // Upper pins fall back to gpio in audio mode
      assign sel_card = (route_ff == CPR0_ROUTE_CARD);
      assign sel_aud  = (route_ff == CPR0_ROUTE_AUDIO)
                        & CPR0_AUDIO_MASK[i];

      always_ff @(posedge mclk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            pad_o_ff[i]  <= 1'b0;
            pad_e_ff[i]  <= 1'b0;
            card_i_ff[i] <= 1'b0;
            aud_i_ff[i]  <= 1'b0;
            gpio_i_ff[i] <= 1'b0;
         end else if (ce_in) begin
            if (sel_card) begin
               pad_o_ff[i] <= card_o[i];
               pad_e_ff[i] <= card_e[i];
            end else if (sel_aud) begin
               pad_o_ff[i] <= aud_o[i];
               pad_e_ff[i] <= aud_e[i];
            end else begin
               pad_o_ff[i] <= gpio_val_in[i];
               pad_e_ff[i] <= gpio_oe_in[i];
            end
            // Unselected functions see a quiet low input
            card_i_ff[i] <= sel_card & pad_in[i];
            aud_i_ff[i]  <= sel_aud & pad_in[i];
            gpio_i_ff[i] <= ~sel_card & ~sel_aud & pad_in[i];
         end
      end
   end

   assign pad_out      = pad_o_ff;
   assign pad_oe_out   = pad_e_ff;
   assign card_cmd_out = card_i_ff[CPR0_PIN_CMD];
   assign card_dat_out = card_i_ff[CPR0_PIN_D3:CPR0_PIN_D0];
   assign aud_clk_out  = aud_i_ff[CPR0_PIN_CLK];
   assign aud_fs_out   = aud_i_ff[CPR0_PIN_CMD];
   assign aud_rx_out   = aud_i_ff[CPR0_PIN_D1];
   assign gpio_pad_out = gpio_i_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   a_clk_card_route: assert property (ce_in && route_ff == CPR0_ROUTE_CARD
      |=> pad_out[0] == $past(card_clk_in) && pad_oe_out[0])
      else $error("clock pin not carrying card clock");
   a_cmd_audio_route: assert property (ce_in && route_ff == CPR0_ROUTE_AUDIO
      |=> pad_out[1] == $past(aud_fs_in) && pad_oe_out[1] == $past(aud_fs_oe_in))
      else $error("command pin not carrying frame sync");
   a_upper_no_audio: assert property (ce_in && route_ff == CPR0_ROUTE_AUDIO
      |=> pad_oe_out[5:4] == $past(gpio_oe_in[5:4]))
      else $error("upper data pins left gpio in audio mode");
   a_lower_audio_dir: assert property (ce_in && route_ff == CPR0_ROUTE_AUDIO
      |=> !pad_oe_out[3] && pad_oe_out[2] && pad_out[2] == $past(aud_dx_in))
      else $error("audio data pins wrong direction");
   a_card_data_bus: assert property (ce_in && route_ff == CPR0_ROUTE_CARD
      |=> pad_oe_out[5:2] == $past(card_dat_oe_in) && pad_out[5:2] == $past(card_dat_in))
      else $error("card data bus not passed through");
   a_route_write: assert property (wr_route
      |=> route_ff == $past(wdata_ff[CPR0_ROUTE_LSB +: CPR0_ROUTE_W]) && s_bvalid_out)
      else $error("route field write lost");
   a_pd_write: assert property (wr_pd ##1 !wr_pd
      |-> pd_inhibit_out == $past(wdata_ff[CPR0_PIN_N-1:0]) ##1 $stable(pd_inhibit_out))
      else $error("pulldown inhibit not held");
   a_flag_set: assert property (ce_in && flag_set_in |=> flag_out)
      else $error("flag not set");
   a_flag_clear: assert property (ce_in && flag_clr_in && !flag_set_in
      |=> !flag_out)
      else $error("flag not cleared");
   a_flag_status_wr: assert property (wr_flag && !flag_set_in && !flag_clr_in
      |=> flag_out == $past(wdata_ff[CPR0_FLAG_BIT]))
      else $error("status write did not reach flag");
   a_flag_driven: assert property ((ce_in && !scan_in)[*2] |=> flag_oe_out)
      else $error("flag floated outside scan");
   a_flag_scan_hiz: assert property (ce_in && scan_in |=> !flag_oe_out)
      else $error("flag driven during scan");
   a_gpio_route: assert property (ce_in && route_ff == CPR0_ROUTE_GPIO
      |=> pad_out == $past(gpio_val_in) && gpio_pad_out == $past(pad_in))
      else $error("gpio routing broken");

   c_card_mode:  cover property (wr_route ##1 route_ff == CPR0_ROUTE_CARD);
   c_audio_mode: cover property (wr_route ##1 route_ff == CPR0_ROUTE_AUDIO);
   c_flag_pulse: cover property (flag_set_in ##1 flag_out ##[1:20] !flag_out);
   c_read_back:  cover property (s_rvalid_out && s_rready_in);

endmodule : cpr0_pin_route
`default_nettype wire

//--- verif/cpr0_pad_model.sv
// Purpose: Far-side device on the six card port zero pads
// Assumes: Card, codec or gpio device driving a pad when enabled
// Notes:   Contention shows as unknown; an unheld pad toggles each cycle
`timescale 1ns/1ps
`default_nettype none
module cpr0_pad_model (
   // Clock
   input  wire logic       mclk_in,
   // Device pad drive
   input  wire logic [5:0] pad_out_in,
   input  wire logic [5:0] pad_oe_in,
   input  wire logic [5:0] pd_inhibit_in,
   // Far device drive, set by the bench
   input  wire logic [5:0] far_val_in,
   input  wire logic [5:0] far_en_in,
   // Resolved pad level
   output logic      [5:0] pad_lvl_out
);
   logic [5:0] float_ff;

   // Floating pads flip so a stale level never passes as real
   always_ff @(posedge mclk_in) begin
      float_ff <= ~pad_lvl_out;
   end

   // Both sides driving is a fault, never quietly resolved
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (pad_oe_in[i] && far_en_in[i])
            pad_lvl_out[i] = 1'bx;
         else if (pad_oe_in[i])
            pad_lvl_out[i] = pad_out_in[i];
         else if (far_en_in[i])
            pad_lvl_out[i] = far_val_in[i];
         else if (!pd_inhibit_in[i])
            pad_lvl_out[i] = 1'b0;
         else
            pad_lvl_out[i] = float_ff[i];
      end
   end
endmodule : cpr0_pad_model
`default_nettype wire

//--- verif/card_port0_pin_routing_test.sv
// Purpose: Self-checking bench for card port zero pin routing
// Assumes: Sequential register accesses, one at a time
// Notes:   Expectations queued by drivers, compared by watchers
`timescale 1ns/1ps
`default_nettype none
module card_port0_pin_routing_test;
   import cpr0_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic        mclk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1;
   logic [3:0]  s_awaddr_in = 4'h0, s_araddr_in = 4'h0, s_wstrb_in = 4'h0;
   logic [31:0] s_wdata_in = 32'h0;
   logic        s_awvalid_in = 1'b0, s_wvalid_in = 1'b0, s_bready_in = 1'b0;
   logic        s_arvalid_in = 1'b0, s_rready_in = 1'b0;
   logic        flag_set_in = 1'b0, flag_clr_in = 1'b0, scan_in = 1'b0;
   logic [27:0] fn = 28'h0;
   logic [5:0]  far_val = 6'h00, pd = 6'h00;
   logic        far_on = 1'b1, eflag = 1'b0, samp = 1'b0;
   logic [1:0]  mode = CPR0_ROUTE_RST;
   logic        s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
   logic [1:0]  s_bresp_out, s_rresp_out;
   logic [31:0] s_rdata_out;
   logic        card_cmd_out, aud_clk_out, aud_fs_out, aud_rx_out, flag_out, flag_oe_out;
   logic [3:0]  card_dat_out;
   logic [5:0]  gpio_pad_out, pad_out, pad_oe_out, pd_inhibit_out;
   wire  [5:0]  pad_in;
   wire  [33:0] obs = {pad_out, pad_oe_out, gpio_pad_out, card_cmd_out, card_dat_out,
                       aud_clk_out, aud_fs_out, aud_rx_out, flag_out, flag_oe_out,
                       pd_inhibit_out};
   logic [33:0] rsp_q[$];
   logic [67:0] pin_q[$];
   int          bad_count = 0, check_count = 0;

   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   cpr0_pin_route DUT (.mclk_in, .resetn_in, .ce_in, .s_awaddr_in, .s_awvalid_in,
      .s_awready_out, .s_wdata_in, .s_wstrb_in, .s_wvalid_in, .s_wready_out, .s_bresp_out,
      .s_bvalid_out, .s_bready_in, .s_araddr_in, .s_arvalid_in, .s_arready_out,
      .s_rdata_out, .s_rresp_out, .s_rvalid_out, .s_rready_in, .card_clk_in(fn[0]),
      .card_cmd_in(fn[1]), .card_cmd_oe_in(fn[2]), .card_cmd_out, .card_dat_in(fn[6:3]),
      .card_dat_oe_in(fn[10:7]), .card_dat_out, .aud_clk_in(fn[11]),
      .aud_clk_oe_in(fn[12]), .aud_clk_out, .aud_fs_in(fn[13]), .aud_fs_oe_in(fn[14]),
      .aud_fs_out, .aud_dx_in(fn[15]), .aud_rx_out, .gpio_val_in(fn[21:16]),
      .gpio_oe_in(fn[27:22]), .gpio_pad_out, .pad_in, .pad_out, .pad_oe_out,
      .pd_inhibit_out, .flag_set_in, .flag_clr_in, .scan_in, .flag_out, .flag_oe_out);
   cpr0_pad_model far (.mclk_in, .pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
      .pd_inhibit_in(pd_inhibit_out), .far_val_in(far_val),
      .far_en_in(far_on ? ~pad_oe_out : 6'h00), // Yields at once, no contention on route change
      .pad_lvl_out(pad_in));

   // Clock, 5 ns period
   initial begin
      forever #2.5 mclk_in = ~mclk_in;
   end

   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task miss(input string m);
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask : miss

   task finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   // Pad drive, enables and returned inputs per route; {mask, value}
   function automatic logic [67:0] expect_pins(input logic [1:0] m);
      logic [5:0] o, e, l, g;
      logic [4:0] c;
      logic [2:0] a;
      g = 6'h00;
      c = 5'h00;
      a = 3'h0;
      case (m)
         CPR0_ROUTE_CARD: begin
            o = {fn[6:3], fn[1], fn[0]};
            e = {fn[10:7], fn[2], 1'b1};
         end
         CPR0_ROUTE_AUDIO: begin
            o = {fn[21:20], 1'b0, fn[15], fn[13], fn[11]};
            e = {fn[27:26], 1'b0, 1'b1, fn[14], fn[12]};
         end
         default: begin
            o = fn[21:16];
            e = fn[27:22];
         end
      endcase
      l = (o & e) | (far_on ? far_val & ~e : 6'h00);
      if (m == CPR0_ROUTE_CARD)
         c = {l[1], l[5:2]};
      else if (m == CPR0_ROUTE_AUDIO)
         {a, g} = {l[0], l[1], l[3], l & 6'h30};
      else
         g = l;
      return {e, 28'hFFFFFFF, o, e, g, c, a, eflag, ~scan_in, pd};
   endfunction : expect_pins

   // Bus answers, taken at their handshake edge
   always @(posedge mclk_in) begin
      if (s_bvalid_out && s_bready_in) begin
         check_count++;
         if (s_bresp_out !== rsp_q.pop_front() >> 32)
            miss("write response");
      end
      if (s_rvalid_out && s_rready_in) begin
         check_count++;
         if ({s_rresp_out, s_rdata_out} !== rsp_q.pop_front())
            miss("read data or response");
      end
   end

   // Pin snapshots, sampled mid-cycle when settled
   always @(negedge mclk_in) begin
      if (samp) begin
         check_count++;
         if (((obs ^ pin_q[0][33:0]) & pin_q[0][67:34]) !== 34'h0)
            miss("pin state");
         void'(pin_q.pop_front());
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
               input logic [1:0] r);
      logic ta, tw, da, dw;
      @(posedge mclk_in);
      rsp_q.push_back({r, 32'h0});
      s_awaddr_in  <= a;
      s_wdata_in   <= d;
      s_wstrb_in   <= s;
      s_awvalid_in <= 1'b1;
      s_wvalid_in  <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      while (!(da && dw)) begin
         @(negedge mclk_in);
         ta = s_awvalid_in && s_awready_out;
         tw = s_wvalid_in && s_wready_out;
         @(posedge mclk_in);
         if (ta) begin
            s_awvalid_in <= 1'b0;
            da = 1'b1;
         end
         if (tw) begin
            s_wvalid_in <= 1'b0;
            dw = 1'b1;
         end
      end
      s_bready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         ta = s_bvalid_out;
         @(posedge mclk_in);
      end while (!ta);
      s_bready_in <= 1'b0;
   endtask : axi_wr

   task axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic t;
      @(posedge mclk_in);
      rsp_q.push_back({r, d});
      s_araddr_in  <= a;
      s_arvalid_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         t = s_arready_out;
         @(posedge mclk_in);
      end while (!t);
      s_arvalid_in <= 1'b0;
      s_rready_in  <= 1'b1;
      do begin
         @(negedge mclk_in);
         t = s_rvalid_out;
         @(posedge mclk_in);
      end while (!t);
      s_rready_in <= 1'b0;
   endtask : axi_rd

   // Two register stages settle before the snapshot
   task pin_chk();
      repeat (4) @(posedge mclk_in);
      pin_q.push_back(expect_pins(mode));
      samp <= 1'b1;
      @(posedge mclk_in);
      samp <= 1'b0;
   endtask : pin_chk

   task pulse(input logic s, input logic c);
      @(posedge mclk_in);
      flag_set_in <= s;
      flag_clr_in <= c;
      @(posedge mclk_in);
      flag_set_in <= 1'b0;
      flag_clr_in <= 1'b0;
   endtask : pulse

   // A hang counts as a failure
   initial begin
      repeat (20000) @(posedge mclk_in);
      bad_count++;
      finish_test();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(26930));
      repeat (12) @(posedge mclk_in);
      resetn_in <= 1'b1;
      axi_rd(CPR0_BUS_SELECT_OFS, {30'h0, CPR0_ROUTE_RST}, CPR0_RESP_OKAY);
      axi_rd(CPR0_PD_INHIBIT_OFS, 32'h0, CPR0_RESP_OKAY);
      axi_rd(CPR0_CPU_STATUS_OFS, 32'h0, CPR0_RESP_OKAY);
      pin_chk();
      // Every route code, random function drive and pulldown pattern
      for (int m = 0; m < 4; m++) begin
         axi_wr(CPR0_BUS_SELECT_OFS, 32'(m), 4'h1, CPR0_RESP_OKAY);
         mode = 2'(m);
         for (int k = 0; k < 3; k++) begin
            pd = 6'($urandom);
            axi_wr(CPR0_PD_INHIBIT_OFS, {26'h0, pd}, 4'h1, CPR0_RESP_OKAY);
            @(posedge mclk_in);
            fn      <= 28'($urandom);
            far_val <= 6'($urandom);
            pin_chk();
         end
      end
      axi_rd(CPR0_PD_INHIBIT_OFS, {26'h0, pd}, CPR0_RESP_OKAY);
      // Pulldowns on, far side released: undriven gpio inputs read low
      pd = 6'h00;
      axi_wr(CPR0_PD_INHIBIT_OFS, 32'h0, 4'hF, CPR0_RESP_OKAY);
      far_on <= 1'b0;
      pin_chk();
      far_on <= 1'b1;
      // Route lane not strobed, unmapped place refused
      axi_wr(CPR0_BUS_SELECT_OFS, 32'hFFFFFFFC, 4'hE, CPR0_RESP_OKAY);
      axi_rd(CPR0_BUS_SELECT_OFS, 32'h3, CPR0_RESP_OKAY);
      axi_wr(4'hC, 32'hFFFFFFFF, 4'hF, CPR0_RESP_SLVERR);
      axi_rd(4'hC, 32'h0, CPR0_RESP_SLVERR);
      // Flag by instruction, status write and scan
      pulse(1'b1, 1'b0);
      eflag = 1'b1;
      pin_chk();
      pulse(1'b0, 1'b1);
      eflag = 1'b0;
      pin_chk();
      @(posedge mclk_in);
      ce_in <= 1'b0;
      pulse(1'b1, 1'b0);
      ce_in <= 1'b1;
      pin_chk();
      pulse(1'b1, 1'b1);
      eflag = 1'b1;
      pin_chk();
      axi_wr(CPR0_CPU_STATUS_OFS, 32'h0, 4'h2, CPR0_RESP_OKAY);
      eflag = 1'b0;
      pin_chk();
      axi_wr(CPR0_CPU_STATUS_OFS, 32'hFFFFFFFF, 4'h1, CPR0_RESP_OKAY);
      pin_chk();
      axi_wr(CPR0_CPU_STATUS_OFS, 32'hFFFFFFFF, 4'hF, CPR0_RESP_OKAY);
      eflag = 1'b1;
      axi_rd(CPR0_CPU_STATUS_OFS, 32'h2000, CPR0_RESP_OKAY);
      @(posedge mclk_in);
      scan_in <= 1'b1;
      pin_chk();
      @(posedge mclk_in);
      scan_in <= 1'b0;
      pin_chk();
      finish_test();
   end
endmodule : card_port0_pin_routing_test
`default_nettype wire
